//--- reset_seq_pkg.sv
// Constants, register map and types of the reset time-out sequencer
`default_nettype none
package reset_seq_pkg;

  // ==========================================================
  // Clock and time figures
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned POWERUP_DELAY_TIME_MS = 72;
  localparam int unsigned LPO_FREQ_HZ = 31250;
  localparam int unsigned POWERUP_DELAY_TICKS =
    (POWERUP_DELAY_TIME_MS * LPO_FREQ_HZ + 999) / 1000;
  localparam int unsigned BROWNOUT_MIN_DURATION_NS = 100;
  localparam int unsigned BOD_CYC_RAW =
    (BROWNOUT_MIN_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] BROWNOUT_MIN_CYCLES =
    8'((BOD_CYC_RAW < 1) ? 1 : BOD_CYC_RAW);
  localparam int unsigned OSC_STARTUP_CYCLES = 1024;
  localparam logic [10:0] OST_LAST = 11'(OSC_STARTUP_CYCLES - 1);

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_CORE_STATUS_FLAGS = 8'h03;
  localparam logic [7:0] ADDR_POWER_RESET_CAUSE = 8'h8E;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h40;
  localparam logic [7:0] ADDR_EVENT_CLEAR = 8'h41;
  localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h42;

  // ==========================================================
  // Field positions
  localparam int unsigned ST_TIMEOUT = 4;
  localparam int unsigned ST_POWERDOWN = 3;
  localparam int unsigned PC_POR = 1;
  localparam int unsigned PC_BROWNOUT = 0;
  localparam int unsigned EV_POR = 0;
  localparam int unsigned EV_BROWNOUT = 1;
  localparam int unsigned EV_WATCHDOG = 2;
  localparam int unsigned EV_EXTRESET = 3;
  localparam int unsigned EV_WAKE = 4;
  localparam int unsigned EV_RELEASE = 5;
  localparam int unsigned EV_COUNT = 6;

  // ==========================================================
  // Reset values and vectors
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [1:0] POWER_RESET_CAUSE_RESET = 2'h0;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // ==========================================================
  // Oscillator modes
  localparam logic [2:0] LOWPOWER_CRYSTAL_MODE = 3'h0;
  localparam logic [2:0] STANDARD_CRYSTAL_MODE = 3'h1;
  localparam logic [2:0] HIGHSPEED_CRYSTAL_MODE = 3'h2;
  localparam logic [2:0] EXTERNAL_CLOCK_MODE = 3'h3;
  localparam logic [2:0] INTERNAL_OSC_MODE = 3'h4;
  localparam logic [2:0] RC_OSC_MODE = 3'h6;

  typedef enum logic [2:0] {
    S_HOLD, S_POWERUP_DELAY_TIMER, S_OST, S_DONE, S_RUN, S_SLEEP
  } seq_state_t;

  typedef enum logic [1:0] {
    C_POR, C_BOD, C_WAKE, C_OTHER
  } cause_t;

endpackage
`default_nettype wire

//--- reset_timeout_sequencer.sv
// Reset sources, start-up delays, reset-cause flags and restart vector
`timescale 1ns/1ps
`default_nettype none
module reset_timeout_sequencer
#(
  parameter int unsigned POWERUP_DELAY_TIMER_TICKS = reset_seq_pkg::POWERUP_DELAY_TICKS
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic por_active,
  input wire logic supply_good_level,
  input wire logic supply_below_trip,
  input wire logic external_reset_pin_n,
  input wire logic oscillator_input_pin,
  input wire logic lpo_clk_in,
  input wire logic brownout_detector_on,
  input wire logic powerup_delay_disable,
  input wire logic [2:0] osc_mode,
  input wire logic wdt_timeout,
  input wire logic sleep_enter,
  input wire logic wake_irq,
  input wire logic global_irq_enable,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  output logic core_reset_n,
  output logic core_sleeping,
  output logic pc_load_valid,
  output logic pc_resume,
  output logic [12:0] pc_vector,
  output logic irq
);
  import reset_seq_pkg::*;

  // ==========================================================
  // Input synchronisers
  localparam int unsigned NSYNC = 6;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  assign async_in = {lpo_clk_in, oscillator_input_pin, external_reset_pin_n,
                     supply_below_trip, supply_good_level, por_active};

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  wire por_s = sync2_q[0];
  wire supply_good_s = sync2_q[1];
  wire below_s = sync2_q[2];
  wire ext_pin_s = sync2_q[3];
  wire osc_s = sync2_q[4];
  wire lpo_s = sync2_q[5];

  logic osc_prev_q;
  logic lpo_prev_q;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_prev_q <= 1'b0;
      lpo_prev_q <= 1'b0;
    end
    else
    begin
      osc_prev_q <= osc_s;
      lpo_prev_q <= lpo_s;
    end
  end
  wire osc_rise = osc_s & ~osc_prev_q;
  wire lpo_rise = lpo_s & ~lpo_prev_q;

  // ==========================================================
  // Brown-out filter
  logic [7:0] bod_cnt_q;
  logic [7:0] bod_cnt_d;
  wire bod_low = brownout_detector_on & below_s;
  wire bod_trip = bod_low & (bod_cnt_q == BROWNOUT_MIN_CYCLES);
  assign bod_cnt_d = !bod_low ? 8'h00 :
                     bod_trip ? bod_cnt_q : bod_cnt_q + 8'h01;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      bod_cnt_q <= 8'h00;
    else
      bod_cnt_q <= bod_cnt_d;
  end

  // ==========================================================
  // Sequencer
  seq_state_t state_q;
  seq_state_t state_d;
  cause_t cause_q;
  cause_t cause_d;
  logic [15:0] powerup_delay_timer_cnt_q;
  logic [10:0] ost_cnt_q;
  logic wake_branch_q;

  wire hard_src = por_s | bod_trip | ~supply_good_s;
  wire xtal_mode = (osc_mode == LOWPOWER_CRYSTAL_MODE) |
                   (osc_mode == STANDARD_CRYSTAL_MODE) |
                   (osc_mode == HIGHSPEED_CRYSTAL_MODE);
  wire power_cause = (cause_q == C_POR) | (cause_q == C_BOD);
  wire powerup_delay_timer_go = ~powerup_delay_disable & power_cause;
  wire ost_go = xtal_mode &
                ((cause_q == C_POR) | (cause_q == C_WAKE));
  wire powerup_delay_timer_done = (state_q == S_POWERUP_DELAY_TIMER) & lpo_rise &
                   (powerup_delay_timer_cnt_q == 16'(POWERUP_DELAY_TIMER_TICKS - 1));
  wire ost_done = (state_q == S_OST) & osc_rise &
                  (ost_cnt_q == OST_LAST);
  wire in_run = (state_q == S_RUN) & ~hard_src;
  wire in_sleep = (state_q == S_SLEEP) & ~hard_src;
  wire ev_external_reset_pin_n_run = in_run & ~ext_pin_s;
  wire ev_external_reset_pin_n_sleep = in_sleep & ~ext_pin_s;
  wire ev_wdt_rst = in_run & ext_pin_s & wdt_timeout;
  wire ev_wdt_wake = in_sleep & ext_pin_s & wdt_timeout;
  wire ev_irq_wake = in_sleep & ext_pin_s & ~wdt_timeout & wake_irq;
  wire ev_sleep = in_run & ext_pin_s & ~wdt_timeout & sleep_enter;
  wire ev_bod = bod_trip & ~por_s;
  wire ev_release = (state_q == S_DONE) & ext_pin_s & ~hard_src;

  always_comb
  begin
    state_d = state_q;
    cause_d = cause_q;
    if (por_s)
    begin
      state_d = S_HOLD;
      cause_d = C_POR;
    end
    else if (hard_src)
    begin
      state_d = S_HOLD;
      if (cause_q != C_POR)
        cause_d = C_BOD;
    end
    else
    begin
      case (state_q)
        S_HOLD:
        begin
          if (powerup_delay_timer_go)
            state_d = S_POWERUP_DELAY_TIMER;
          else if (ost_go)
            state_d = S_OST;
          else
            state_d = S_DONE;
        end
        S_POWERUP_DELAY_TIMER:
        begin
          if (powerup_delay_timer_done)
            state_d = ost_go ? S_OST : S_DONE;
        end
        S_OST:
        begin
          if (ost_done)
            state_d = S_DONE;
        end
        S_DONE:
        begin
          if (ext_pin_s)
            state_d = S_RUN;
        end
        S_RUN:
        begin
          if (ev_external_reset_pin_n_run | ev_wdt_rst)
          begin
            state_d = S_DONE;
            cause_d = C_OTHER;
          end
          else if (ev_sleep)
            state_d = S_SLEEP;
        end
        S_SLEEP:
        begin
          if (ev_external_reset_pin_n_sleep)
          begin
            state_d = S_DONE;
            cause_d = C_OTHER;
          end
          else if (ev_wdt_wake | ev_irq_wake)
          begin
            state_d = xtal_mode ? S_OST : S_DONE;
            cause_d = C_WAKE;
          end
        end
        default:
          state_d = S_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_HOLD;
      cause_q <= C_POR;
    end
    else
    begin
      state_q <= state_d;
      cause_q <= cause_d;
    end
  end

  // Delay counters, cleared whenever their state is left
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      powerup_delay_timer_cnt_q <= 16'h0000;
      ost_cnt_q <= 11'h000;
    end
    else
    begin
      if (state_d != S_POWERUP_DELAY_TIMER || state_q != S_POWERUP_DELAY_TIMER)
        powerup_delay_timer_cnt_q <= 16'h0000;
      else if (lpo_rise)
        powerup_delay_timer_cnt_q <= powerup_delay_timer_cnt_q + 16'h0001;
      if (state_d != S_OST || state_q != S_OST)
        ost_cnt_q <= 11'h000;
      else if (osc_rise)
        ost_cnt_q <= ost_cnt_q + 11'h001;
    end
  end

  // ==========================================================
  // Register writes and reset-cause flags
  logic [7:0] status_q;
  logic [1:0] power_reset_cause_q;
  logic [EV_COUNT-1:0] ev_stat_q;
  logic [EV_COUNT-1:0] ev_en_q;
  logic [EV_COUNT-1:0] ev_set;

  wire wr_status = reg_we & (reg_addr == ADDR_CORE_STATUS_FLAGS);
  wire wr_power_reset_cause = reg_we & (reg_addr == ADDR_POWER_RESET_CAUSE);
  wire wr_clear = reg_we & (reg_addr == ADDR_EVENT_CLEAR);
  wire wr_enable = reg_we & (reg_addr == ADDR_EVENT_ENABLE);
  wire bank_clear = ev_external_reset_pin_n_run | ev_external_reset_pin_n_sleep | ev_wdt_rst;

  assign ev_set = {ev_release, ev_wdt_wake | ev_irq_wake,
                   ev_external_reset_pin_n_run | ev_external_reset_pin_n_sleep, ev_wdt_rst | ev_wdt_wake,
                   ev_bod, por_s};

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_q <= STATUS_RESET;
      power_reset_cause_q <= POWER_RESET_CAUSE_RESET;
    end
    else
    begin
      // Software first; hardware events below win in the same cycle
      if (wr_status)
      begin
        status_q[7:5] <= reg_wdata[7:5];
        status_q[2:0] <= reg_wdata[2:0];
      end
      if (wr_power_reset_cause)
        power_reset_cause_q <= reg_wdata[1:0];
      if (por_s | ev_bod)
      begin
        status_q[7:3] <= STATUS_RESET[7:3];
      end
      if (por_s)
        power_reset_cause_q[PC_POR] <= 1'b0;
      if (ev_bod)
      begin
        power_reset_cause_q[PC_POR] <= 1'b1;
        power_reset_cause_q[PC_BROWNOUT] <= 1'b0;
      end
      if (bank_clear)
        status_q[7:5] <= 3'h0;
      if (ev_wdt_rst)
        status_q[ST_TIMEOUT] <= 1'b0;
      if (ev_wdt_wake)
      begin
        status_q[ST_TIMEOUT] <= 1'b0;
        status_q[ST_POWERDOWN] <= 1'b0;
      end
      if (ev_external_reset_pin_n_sleep | ev_irq_wake)
      begin
        status_q[ST_TIMEOUT] <= 1'b1;
        status_q[ST_POWERDOWN] <= 1'b0;
      end
      if (ev_sleep)
      begin
        status_q[ST_TIMEOUT] <= 1'b1;
        status_q[ST_POWERDOWN] <= 1'b0;
      end
    end
  end

  // Event status: set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ev_stat_q <= '0;
      ev_en_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      ev_stat_q <= (ev_stat_q &
                    ~(wr_clear ? reg_wdata[EV_COUNT-1:0] : '0)) | ev_set;
      if (wr_enable)
        ev_en_q <= reg_wdata[EV_COUNT-1:0];
      irq <= |(ev_stat_q & ev_en_q);
    end
  end

  // ==========================================================
  // Read port
  logic [7:0] rd_mux;
  assign rd_mux =
    (reg_addr == ADDR_CORE_STATUS_FLAGS) ? status_q :
    (reg_addr == ADDR_POWER_RESET_CAUSE) ? {6'h00, power_reset_cause_q} :
    (reg_addr == ADDR_EVENT_STATUS) ? {2'h0, ev_stat_q} :
    (reg_addr == ADDR_EVENT_ENABLE) ? {2'h0, ev_en_q} : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_re ? rd_mux : 8'h00;
  end

  // ==========================================================
  // Core release and restart vector
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_reset_n <= 1'b0;
      core_sleeping <= 1'b0;
      pc_load_valid <= 1'b0;
      pc_resume <= 1'b0;
      pc_vector <= RESET_VECTOR;
      wake_branch_q <= 1'b0;
    end
    else
    begin
      core_reset_n <= (state_d == S_RUN) | (state_d == S_SLEEP);
      core_sleeping <= (state_d == S_SLEEP);
      if (ev_irq_wake)
        wake_branch_q <= global_irq_enable;
      else if (ev_wdt_wake | ev_external_reset_pin_n_sleep)
        wake_branch_q <= 1'b0;
      pc_load_valid <= ev_release;
      if (ev_release)
      begin
        pc_resume <= (cause_q == C_WAKE);
        pc_vector <= ((cause_q == C_WAKE) & wake_branch_q) ?
                     IRQ_VECTOR : RESET_VECTOR;
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_ost_full;
    (state_q == S_OST && state_d == S_DONE) |->
      (ost_cnt_q == OST_LAST && osc_rise);
  endproperty
  a_ost_full: assert property (p_ost_full)
    else $error("oscillator count ended early");

  property p_ost_only_xtal;
    (state_q != S_OST && state_d == S_OST) |-> xtal_mode &&
      (cause_q == C_POR || cause_q == C_WAKE || cause_d == C_WAKE);
  endproperty
  a_ost_only_xtal: assert property (p_ost_only_xtal)
    else $error("oscillator count started in wrong mode");

  property p_bod_enable;
    bod_trip |-> brownout_detector_on;
  endproperty
  a_bod_enable: assert property (p_bod_enable)
    else $error("brown-out trip while detector off");

  property p_bod_reset;
    bod_trip |=> (state_q == S_HOLD && !core_reset_n);
  endproperty
  a_bod_reset: assert property (p_bod_reset)
    else $error("brown-out did not reset");

  property p_powerup_delay_timer_disable;
    (state_q != S_POWERUP_DELAY_TIMER && state_d == S_POWERUP_DELAY_TIMER) |-> !powerup_delay_disable;
  endproperty
  a_powerup_delay_timer_disable: assert property (p_powerup_delay_timer_disable)
    else $error("power-up delay ran while disabled");

  property p_powerup_delay_timer_restart;
    (state_q == S_POWERUP_DELAY_TIMER && !supply_good_s) |=>
      (state_q == S_HOLD && powerup_delay_timer_cnt_q == 16'h0000);
  endproperty
  a_powerup_delay_timer_restart: assert property (p_powerup_delay_timer_restart)
    else $error("power-up delay not restarted");

  property p_no_delay_ext;
    (state_q == S_HOLD && !hard_src && powerup_delay_disable &&
     osc_mode == EXTERNAL_CLOCK_MODE) |=> state_q == S_DONE;
  endproperty
  a_no_delay_ext: assert property (p_no_delay_ext)
    else $error("external clock release was delayed");

  property p_pin_release;
    (state_q == S_DONE && ext_pin_s && !hard_src) |=>
      (core_reset_n && pc_load_valid);
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("pin release did not start execution");

  property p_por_flag;
    $fell(power_reset_cause_q[PC_POR]) |-> $past(por_s) ||
      $past(wr_power_reset_cause && !reg_wdata[PC_POR]);
  endproperty
  a_por_flag: assert property (p_por_flag)
    else $error("power-on flag cleared without power-on");

  property p_vector;
    pc_load_valid |-> (pc_resume ? 1'b1 : pc_vector == RESET_VECTOR);
  endproperty
  a_vector: assert property (p_vector)
    else $error("reset did not restart at zero");

  property p_irq_branch;
    (ev_irq_wake && global_irq_enable) ##1 (!ev_external_reset_pin_n_sleep)[*1] |->
      wake_branch_q;
  endproperty
  a_irq_branch: assert property (p_irq_branch)
    else $error("interrupt wake lost its branch");

endmodule // reset_timeout_sequencer
`default_nettype wire

//--- reset_timeout_sequencer_tb_top.sv
// Self-checking testbench of the reset time-out sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_timeout_sequencer_tb_top;
  import reset_seq_pkg::*;

  // ==========================================================
  // Stimulus and observed signals
  localparam int PT = 4;
  localparam int OST_SPAN = 2 * OSC_STARTUP_CYCLES;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic por_active = 1'b1;
  logic supply_good_level = 1'b0;
  logic supply_below_trip = 1'b0;
  logic external_reset_pin_n = 1'b1;
  logic oscillator_input_pin = 1'b0;
  logic lpo_clk_in = 1'b0;
  logic brownout_detector_on = 1'b1;
  logic powerup_delay_disable = 1'b0;
  logic [2:0] osc_mode = STANDARD_CRYSTAL_MODE;
  logic wdt_timeout = 1'b0;
  logic sleep_enter = 1'b0;
  logic wake_irq = 1'b0;
  logic global_irq_enable = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_rdata;
  logic core_reset_n, core_sleeping, pc_load_valid, pc_resume, irq;
  logic [12:0] pc_vector;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int ld_n;
  logic [12:0] ld_vec;
  logic ld_res;
  logic [2:0] modes [6];

  reset_timeout_sequencer #(.POWERUP_DELAY_TIMER_TICKS(PT)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .por_active(por_active),
    .supply_good_level(supply_good_level),
    .supply_below_trip(supply_below_trip),
    .external_reset_pin_n(external_reset_pin_n),
    .oscillator_input_pin(oscillator_input_pin), .lpo_clk_in(lpo_clk_in),
    .brownout_detector_on(brownout_detector_on),
    .powerup_delay_disable(powerup_delay_disable), .osc_mode(osc_mode),
    .wdt_timeout(wdt_timeout), .sleep_enter(sleep_enter),
    .wake_irq(wake_irq), .global_irq_enable(global_irq_enable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .core_reset_n(core_reset_n),
    .core_sleeping(core_sleeping), .pc_load_valid(pc_load_valid),
    .pc_resume(pc_resume), .pc_vector(pc_vector), .irq(irq)
  );

  // ==========================================================
  // Clocks and hang guard
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    oscillator_input_pin <= ~oscillator_input_pin;
    lpo_clk_in <= ~lpo_clk_in;
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      miscompares++;
      $display("timeout at %0t", $time);
      summarize();
    end
  end

  // ==========================================================
  // Access and compare tasks
  task automatic summarize;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_span(input int n, input int lo, input int hi);
    n_compared++;
    if (n < lo || n > hi)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, n, lo);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  task automatic check_reg(input logic [7:0] a, input logic [7:0] m,
                           input logic [7:0] e);
    logic [7:0] d;
    reg_read(a, d);
    check(16'(d & m), 16'(e));
  endtask

  task automatic check_late(input logic got_sel, input logic e);
    repeat (3) @(negedge clk_sys);
    check(16'(got_sel ? irq : core_sleeping), 16'(e));
  endtask

  // Kind 0 watchdog, 1 sleep, 2 interrupt wake
  task automatic pulse(input int k);
    @(posedge clk_sys);
    case (k)
      0: wdt_timeout <= 1'b1;
      1: sleep_enter <= 1'b1;
      default: wake_irq <= 1'b1;
    endcase
    @(posedge clk_sys);
    wdt_timeout <= 1'b0;
    sleep_enter <= 1'b0;
    wake_irq <= 1'b0;
  endtask

  task automatic do_por(input logic [2:0] m, input logic dis);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    por_active <= 1'b1;
    supply_good_level <= 1'b0;
    osc_mode <= m;
    powerup_delay_disable <= dis;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    supply_good_level <= 1'b1;
    por_active <= 1'b0;
  endtask

  task automatic wait_load(input int maxc);
    ld_n = 0;
    do
    begin
      @(negedge clk_sys);
      ld_n++;
    end
    while (pc_load_valid !== 1'b1 && ld_n < maxc);
    ld_vec = pc_vector;
    ld_res = pc_resume;
    if (pc_load_valid !== 1'b1)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time,
               pc_load_valid, 1'b1);
    end
  endtask

  task automatic ext_pin_pulse;
    @(posedge clk_sys);
    external_reset_pin_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    external_reset_pin_n <= 1'b1;
    wait_load(100);
  endtask

  // ==========================================================
  // Test sequence
  initial
  begin
    modes = '{LOWPOWER_CRYSTAL_MODE, STANDARD_CRYSTAL_MODE,
              HIGHSPEED_CRYSTAL_MODE, EXTERNAL_CLOCK_MODE,
              INTERNAL_OSC_MODE, RC_OSC_MODE};
    do_por(STANDARD_CRYSTAL_MODE, 1'b0);
    wait_load(3000);
    check_span(ld_n, OST_SPAN, OST_SPAN + 2 * PT + 60);
    check(16'(ld_vec), 16'h0000);
    check(16'(ld_res), 16'h0000);
    check_reg(ADDR_CORE_STATUS_FLAGS, 8'hFF, 8'h18);
    check_reg(ADDR_POWER_RESET_CAUSE, 8'h02, 8'h00);
    reg_write(ADDR_POWER_RESET_CAUSE, 8'h03);
    check_reg(ADDR_POWER_RESET_CAUSE, 8'hFF, 8'h03);
    reg_write(ADDR_EVENT_ENABLE, 8'h3F);
    check_late(1'b1, 1'b1);
    check_reg(ADDR_EVENT_STATUS, 8'h21, 8'h21);
    reg_write(ADDR_EVENT_CLEAR, 8'h3F);
    check_reg(ADDR_EVENT_STATUS, 8'hFF, 8'h00);
    check_late(1'b1, 1'b0);
    check_reg(8'h55, 8'hFF, 8'h00);
    reg_write(ADDR_EVENT_ENABLE, 8'h04);
    check_reg(ADDR_EVENT_ENABLE, 8'hFF, 8'h04);
    // Watchdog reset in run: banks cleared, time-out flag low
    reg_write(ADDR_CORE_STATUS_FLAGS, 8'hE7);
    check_reg(ADDR_CORE_STATUS_FLAGS, 8'hFF, 8'hFF);
    pulse(0);
    wait_load(100);
    check(16'(ld_vec), 16'h0000);
    check_reg(ADDR_CORE_STATUS_FLAGS, 8'hFF, 8'h0F);
    check_reg(ADDR_POWER_RESET_CAUSE, 8'hFF, 8'h03);
    check_late(1'b1, 1'b1);
    reg_write(ADDR_EVENT_ENABLE, 8'h00);
    check_late(1'b1, 1'b0);
    reg_write(ADDR_EVENT_ENABLE, 8'h04);
    check_late(1'b1, 1'b1);
    reg_write(ADDR_EVENT_CLEAR, 8'h04);
    check_late(1'b1, 1'b0);
    // External reset in normal operation
    reg_write(ADDR_CORE_STATUS_FLAGS, 8'hE7);
    ext_pin_pulse();
    check(16'(ld_res), 16'h0000);
    check_reg(ADDR_CORE_STATUS_FLAGS, 8'hFF, 8'h0F);
    // Watchdog wake from sleep
    pulse(1);
    check_late(1'b0, 1'b1);
    check_reg(ADDR_CORE_STATUS_FLAGS, 8'hFF, 8'h17);
    pulse(0);
    wait_load(3000);
    check_span(ld_n, OST_SPAN - 4, OST_SPAN + 60);
    check(16'(ld_res), 16'h0001);
    check_reg(ADDR_CORE_STATUS_FLAGS, 8'hFF, 8'h07);
    // Interrupt wake with global enable
    @(posedge clk_sys);
    global_irq_enable <= 1'b1;
    pulse(1);
    repeat (4) @(posedge clk_sys);
    pulse(2);
    wait_load(3000);
    check(16'(ld_vec), 16'h0004);
    check(16'(ld_res), 16'h0001);
    check_reg(ADDR_CORE_STATUS_FLAGS, 8'hFF, 8'h17);
    // Interrupt wake without global enable restarts at zero
    @(posedge clk_sys);
    global_irq_enable <= 1'b0;
    pulse(1);
    repeat (4) @(posedge clk_sys);
    pulse(2);
    wait_load(3000);
    check(16'(ld_vec), 16'h0000);
    check(16'(ld_res), 16'h0001);
    // External reset during sleep
    pulse(1);
    repeat (4) @(posedge clk_sys);
    ext_pin_pulse();
    check(16'(ld_vec), 16'h0000);
    check(16'(ld_res), 16'h0000);
    check_reg(ADDR_CORE_STATUS_FLAGS, 8'hFF, 8'h17);
    // Sustained brown-out with the detector on
    @(posedge clk_sys);
    supply_below_trip <= 1'b1;
    supply_good_level <= 1'b0;
    repeat (12) @(negedge clk_sys);
    check(16'(core_reset_n), 16'h0000);
    @(posedge clk_sys);
    supply_below_trip <= 1'b0;
    supply_good_level <= 1'b1;
    // Supply lost again while the power-up delay runs
    repeat (4) @(posedge clk_sys);
    supply_good_level <= 1'b0;
    repeat (4) @(posedge clk_sys);
    supply_good_level <= 1'b1;
    wait_load(3000);
    check_span(ld_n, 2 * PT, 2 * PT + 8);
    check(16'(ld_vec), 16'h0000);
    check_reg(ADDR_POWER_RESET_CAUSE, 8'hFF, 8'h02);
    check_reg(ADDR_CORE_STATUS_FLAGS, 8'hF8, 8'h18);
    check_reg(ADDR_EVENT_STATUS, 8'h02, 8'h02);
    // Start-up delay per oscillator mode, delay disabled
    @(posedge clk_sys);
    brownout_detector_on <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      do_por(modes[i], 1'b1);
      wait_load(3000);
      if (i < 3)
        check_span(ld_n, OST_SPAN - 4, OST_SPAN + 60);
      else
        check_span(ld_n, 0, 20);
    end
    // Detector off: supply dip is ignored
    @(posedge clk_sys);
    supply_below_trip <= 1'b1;
    repeat (20) @(negedge clk_sys);
    check(16'(core_reset_n), 16'h0001);
    @(posedge clk_sys);
    supply_below_trip <= 1'b0;
    // Pin held low past the delays releases at once
    external_reset_pin_n <= 1'b0;
    do_por(STANDARD_CRYSTAL_MODE, 1'b0);
    repeat (2300) @(negedge clk_sys);
    check(16'(core_reset_n), 16'h0000);
    @(posedge clk_sys);
    external_reset_pin_n <= 1'b1;
    wait_load(40);
    check_span(ld_n, 0, 10);
    check_reg(ADDR_POWER_RESET_CAUSE, 8'h02, 8'h00);
    summarize();
  end
endmodule // reset_timeout_sequencer_tb_top
`default_nettype wire
